// ---- rtl/pcsu_loop.sv ----
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "pcsu_params.svh"
module pcsu_loop
   import pcsu_pkg::*;
#(
   parameter int T_W = 16
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire pcsu_cfg_s i_cfg,
   input wire pcsu_ctrl_s i_ctrl,
   input wire logic i_fabric_rst,
   input wire logic i_ref_pin,
   input wire logic i_rst_pin,
   input wire logic i_fb_pin,
   output logic o_primary,
   output logic o_secondary,
   output logic o_lock
);

   localparam int CNT_W = `PCSU_DIV_W + 1;
   localparam logic [T_W-1:0] HALF_INIT = T_W'(`PCSU_HALF_INIT);
   localparam logic [T_W-1:0] HALF_MAX = {T_W{1'b1}};
   localparam logic [CNT_W-1:0] FB_MAX = {CNT_W{1'b1}};
   localparam logic [3:0] LAST_WIN = 4'(`PCSU_LOCK_WINDOWS - 1);
   // room for a window of up to 255 reference periods
   localparam int PH_W = T_W + `PCSU_DIV_W;
   localparam logic [PH_W-1:0] PH_MAX = {PH_W{1'b1}};

   // zero in a divider field behaves as divide by one
   function automatic pcsu_div_t nz(input pcsu_div_t d);
      return (d == '0) ? pcsu_div_t'(1) : d;
   endfunction

   logic ref_s1_reg, ref_s2_reg, ref_s3_reg;
   logic fb_s1_reg, fb_s2_reg, fb_s3_reg;
   logic rstp_s1_reg, rstp_s2_reg;
   pcsu_state_e state_reg, state_next;
   logic [T_W-1:0] half_reg, half_next, vco_cnt_reg, vco_cnt_next;
   pcsu_div_t post_cnt_reg, post_cnt_next, sec_cnt_reg, sec_cnt_next, ref_cnt_reg, ref_cnt_next;
   logic [CNT_W-1:0] fb_cnt_reg, fb_cnt_next;
   logic [3:0] win_cnt_reg, win_cnt_next;
   logic pri_reg, pri_next, pri_d_reg, sec_reg, sec_next, lock_reg, lock_next;
   logic loop_rst, ref_edge, fb_edge, win_end, vco_tick;
   pcsu_div_t m_eff, n_eff, v_eff, k_eff;
   logic [PH_W-1:0] ph_cnt_reg, ph_cnt_next, ph_first_reg, ph_first_next, ph_prev_reg, ph_prev_next;
   logic ph_seen_reg, ph_seen_next, ph_ok_reg, ph_ok_next;
   logic judged, ph_early, ph_late;

   always_comb begin
      m_eff = nz(i_cfg.ref_div);
      n_eff = nz(i_cfg.loop_mul);
      v_eff = nz(i_cfg.post_div);
      k_eff = nz(i_cfg.sec_div);
      loop_rst = i_ctrl.rst_from_pin ? rstp_s2_reg : (i_fabric_rst | i_ctrl.sw_rst);
      ref_edge = ref_s2_reg & ~ref_s3_reg;
      // board-level alignment closes the loop through a pin, device-level through the own net
      fb_edge = i_ctrl.fb_from_pin ? (fb_s2_reg & ~fb_s3_reg) : (pri_reg & ~pri_d_reg);
      win_end = ref_edge && (ref_cnt_reg >= m_eff - pcsu_div_t'(1));
      vco_tick = (vco_cnt_reg >= half_reg - T_W'(1));
      // an equal edge count alone lets a near frequency pass; the first edge must also hold its place
      judged = ph_ok_reg & ph_seen_reg;
      ph_early = judged && (ph_first_reg + PH_W'(1) < ph_prev_reg);
      ph_late = judged && (ph_first_reg > ph_prev_reg + PH_W'(1));
      state_next = state_reg;
      half_next = half_reg;
      vco_cnt_next = vco_cnt_reg + T_W'(1);
      post_cnt_next = post_cnt_reg;
      sec_cnt_next = sec_cnt_reg;
      pri_next = pri_reg;
      sec_next = sec_reg;
      ref_cnt_next = ref_cnt_reg;
      fb_cnt_next = fb_cnt_reg;
      win_cnt_next = win_cnt_reg;
      ph_cnt_next = (ph_cnt_reg != PH_MAX) ? ph_cnt_reg + PH_W'(1) : ph_cnt_reg;
      ph_first_next = ph_first_reg;
      ph_prev_next = ph_prev_reg;
      ph_seen_next = ph_seen_reg;
      ph_ok_next = ph_ok_reg;
      if (vco_tick) begin
         vco_cnt_next = '0;
         // oscillator runs post_div times faster than the primary output
         if (post_cnt_reg >= v_eff - pcsu_div_t'(1)) begin
            post_cnt_next = '0;
            pri_next = ~pri_reg;
            if (sec_cnt_reg >= k_eff - pcsu_div_t'(1)) begin
               sec_cnt_next = '0;
               sec_next = ~sec_reg;
            end else begin
               sec_cnt_next = sec_cnt_reg + pcsu_div_t'(1);
            end
         end else begin
            post_cnt_next = post_cnt_reg + pcsu_div_t'(1);
         end
      end
      if (!i_ctrl.sec_en) begin
         sec_next = 1'b0;
         sec_cnt_next = '0;
      end
      if (ref_edge) begin
         ref_cnt_next = win_end ? '0 : ref_cnt_reg + pcsu_div_t'(1);
      end
      if (win_end) begin
         fb_cnt_next = fb_edge ? CNT_W'(1) : '0;
      end else if (fb_edge && fb_cnt_reg != FB_MAX) begin
         fb_cnt_next = fb_cnt_reg + CNT_W'(1);
      end
      if (win_end) begin
         ph_cnt_next = PH_W'(1);
         ph_prev_next = ph_first_reg;
         ph_ok_next = ph_seen_reg;
         ph_seen_next = fb_edge;
         ph_first_next = '0;
      end else if (fb_edge && !ph_seen_reg) begin
         ph_seen_next = 1'b1;
         ph_first_next = ph_cnt_reg;
      end
      case (state_reg)
         PCSU_ST_RESET: begin
            state_next = PCSU_ST_ACQUIRE;
         end
         PCSU_ST_ACQUIRE, PCSU_ST_LOCKED: begin
            // feedback edges per ref_div reference edges must equal loop_mul
            if (win_end) begin
               // a drifting first edge steers like a count error; a step voids the next window's judgement
               if (fb_cnt_reg < {1'b0, n_eff} || (fb_cnt_reg == {1'b0, n_eff} && ph_late)) begin
                  half_next = (half_reg > T_W'(1)) ? half_reg - T_W'(1) : half_reg;
                  win_cnt_next = '0;
                  ph_ok_next = 1'b0;
                  state_next = PCSU_ST_ACQUIRE;
               end else if (fb_cnt_reg > {1'b0, n_eff} || ph_early) begin
                  half_next = (half_reg != HALF_MAX) ? half_reg + T_W'(1) : half_reg;
                  win_cnt_next = '0;
                  ph_ok_next = 1'b0;
                  state_next = PCSU_ST_ACQUIRE;
               end else if (!judged) begin
                  win_cnt_next = '0;
               end else if (state_reg == PCSU_ST_ACQUIRE) begin
                  if (win_cnt_reg == LAST_WIN) begin
                     state_next = PCSU_ST_LOCKED;
                  end else begin
                     win_cnt_next = win_cnt_reg + 4'h1;
                  end
               end
            end
         end
         default: begin
            state_next = PCSU_ST_RESET;
         end
      endcase
      if (loop_rst) begin
         state_next = PCSU_ST_RESET;
         half_next = HALF_INIT;
         vco_cnt_next = '0;
         post_cnt_next = '0;
         sec_cnt_next = '0;
         pri_next = 1'b0;
         sec_next = 1'b0;
         ref_cnt_next = '0;
         fb_cnt_next = '0;
         win_cnt_next = '0;
         ph_cnt_next = '0;
         ph_first_next = '0;
         ph_prev_next = '0;
         ph_seen_next = 1'b0;
         ph_ok_next = 1'b0;
      end
      lock_next = (state_next == PCSU_ST_LOCKED);
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         ref_s1_reg <= 1'b0;
         ref_s2_reg <= 1'b0;
         ref_s3_reg <= 1'b0;
         fb_s1_reg <= 1'b0;
         fb_s2_reg <= 1'b0;
         fb_s3_reg <= 1'b0;
         rstp_s1_reg <= 1'b0;
         rstp_s2_reg <= 1'b0;
         state_reg <= PCSU_ST_RESET;
         half_reg <= HALF_INIT;
         vco_cnt_reg <= '0;
         post_cnt_reg <= '0;
         sec_cnt_reg <= '0;
         pri_reg <= 1'b0;
         pri_d_reg <= 1'b0;
         sec_reg <= 1'b0;
         ref_cnt_reg <= '0;
         fb_cnt_reg <= '0;
         win_cnt_reg <= '0;
         ph_cnt_reg <= '0;
         ph_first_reg <= '0;
         ph_prev_reg <= '0;
         ph_seen_reg <= 1'b0;
         ph_ok_reg <= 1'b0;
         lock_reg <= 1'b0;
      end else begin
         ref_s1_reg <= i_ref_pin;
         ref_s2_reg <= ref_s1_reg;
         ref_s3_reg <= ref_s2_reg;
         fb_s1_reg <= i_fb_pin;
         fb_s2_reg <= fb_s1_reg;
         fb_s3_reg <= fb_s2_reg;
         rstp_s1_reg <= i_rst_pin;
         rstp_s2_reg <= rstp_s1_reg;
         state_reg <= state_next;
         half_reg <= half_next;
         vco_cnt_reg <= vco_cnt_next;
         post_cnt_reg <= post_cnt_next;
         sec_cnt_reg <= sec_cnt_next;
         pri_reg <= pri_next;
         pri_d_reg <= pri_reg;
         sec_reg <= sec_next;
         ref_cnt_reg <= ref_cnt_next;
         fb_cnt_reg <= fb_cnt_next;
         win_cnt_reg <= win_cnt_next;
         ph_cnt_reg <= ph_cnt_next;
         ph_first_reg <= ph_first_next;
         ph_prev_reg <= ph_prev_next;
         ph_seen_reg <= ph_seen_next;
         ph_ok_reg <= ph_ok_next;
         lock_reg <= lock_next;
      end
   end

   assign o_primary = pri_reg;
   assign o_secondary = sec_reg;
   assign o_lock = lock_reg;

endmodule

// ---- rtl/pcsu_params.svh ----
`ifndef PCSU_PARAMS_SVH
`define PCSU_PARAMS_SVH

// register byte offsets; loop n configuration sits at CFG_BASE + 4*n
`define PCSU_ADDR_W 12
`define PCSU_CFG_BASE 12'h000
`define PCSU_CTRL_OFF 12'h020
`define PCSU_LOCK_OFF 12'h024
`define PCSU_ISTAT_OFF 12'h028
`define PCSU_IMASK_OFF 12'h02c

// configuration word fields, one byte per divider
`define PCSU_DIV_W 8
`define PCSU_REF_DIV_LSB 0
`define PCSU_LOOP_MUL_LSB 8
`define PCSU_POST_DIV_LSB 16
`define PCSU_SEC_DIV_LSB 24
`define PCSU_CFG_RESET 32'h01010101

// control word fields, one bit per loop in each byte
`define PCSU_SEC_EN_LSB 0
`define PCSU_RST_PIN_LSB 8
`define PCSU_FB_PIN_LSB 16
`define PCSU_SW_RST_LSB 24
`define PCSU_CTRL_RESET 32'h00000000

// interrupt status and mask fields
`define PCSU_GAIN_LSB 0
`define PCSU_LOSS_LSB 8
`define PCSU_IRQ_W 16
`define PCSU_IMASK_RESET 16'h0000

// loop behaviour
`define PCSU_MAX_LOOPS 8
`define PCSU_LOCK_WINDOWS 4
`define PCSU_HALF_INIT 8

`endif

// ---- rtl/pcsu_pkg.sv ----
package pcsu_pkg;
`include "pcsu_params.svh"

   typedef logic [`PCSU_DIV_W-1:0] pcsu_div_t;

   // field order matches the configuration word, reference divider lowest
   typedef struct packed {
      pcsu_div_t sec_div;
      pcsu_div_t post_div;
      pcsu_div_t loop_mul;
      pcsu_div_t ref_div;
   } pcsu_cfg_s;

   typedef struct packed {
      logic sec_en;
      logic rst_from_pin;
      logic fb_from_pin;
      logic sw_rst;
   } pcsu_ctrl_s;

   typedef enum logic [2:0] {
      PCSU_ST_RESET = 3'b001,
      PCSU_ST_ACQUIRE = 3'b010,
      PCSU_ST_LOCKED = 3'b100
   } pcsu_state_e;

endpackage

// ---- rtl/pcsu_top.sv ----
`timescale 1ns/1ps
`include "pcsu_params.svh"
// Function
// - up to eight identical synthesis loops, one unit instance each
// - loop n takes reference from pin n and drives primary onto net n
// - optional divided secondary clock drives the next net up, the top loop's wrapping to net 0
// - every loop has its own reset, feedback and lock signals
// - loop reset selectable between fabric signal and dedicated pin
// - feedback selectable between dedicated pin and own global net
// - lock indication goes out to fabric through one register stage
// - four divider settings per loop set the output frequencies
// - reference divider divides, loop factor multiplies
// - post-scaler lets oscillator run faster than primary output
// - secondary divider divides primary, used only when secondary enabled
// - feedback source selects board-level or device-level alignment
module pcsu_top
   import pcsu_pkg::*;
#(
   parameter int NUM_LOOPS = 8,
   parameter int T_W = 16
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [`PCSU_ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [NUM_LOOPS-1:0] i_global_clock_pin,
   input wire logic [NUM_LOOPS-1:0] i_loop_reset_pin,
   input wire logic [NUM_LOOPS-1:0] i_loop_feedback_in,
   input wire logic [NUM_LOOPS-1:0] i_fabric_reset,
   output logic [NUM_LOOPS-1:0] o_global_net,
   output logic [NUM_LOOPS-1:0] o_loop_lock,
   output logic o_irq
);

   localparam int ML = `PCSU_MAX_LOOPS;

   if (NUM_LOOPS < 1 || NUM_LOOPS > ML) begin : g_bad_count
      $error("pcsu_top: NUM_LOOPS must be 1 to 8");
   end
   if (T_W < 4 || T_W > 24) begin : g_bad_width
      $error("pcsu_top: T_W must be 4 to 24");
   end

   // byte-lane merge for writable registers
   function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic is_cfg(input logic [`PCSU_ADDR_W-1:0] a);
      return (a[`PCSU_ADDR_W-1:5] == `PCSU_CFG_BASE >> 5) && (32'(a[4:2]) < NUM_LOOPS);
   endfunction

   function automatic logic hit(input logic [`PCSU_ADDR_W-1:0] a, input logic [`PCSU_ADDR_W-1:0] off);
      return a[`PCSU_ADDR_W-1:2] == off[`PCSU_ADDR_W-1:2];
   endfunction

   pcsu_cfg_s cfg_reg [ML];
   pcsu_cfg_s cfg_next [ML];
   logic [31:0] ctrl_reg, ctrl_next;
   logic [`PCSU_IRQ_W-1:0] istat_reg, istat_next, imask_reg, imask_next;
   logic [ML-1:0] lock_d_reg;
   logic [NUM_LOOPS-1:0] net_reg, net_next, lock_out_reg;
   logic irq_reg, irq_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next, pslverr_reg, pslverr_next;
   logic access, take, wr, mapped;
   logic [ML-1:0] pri_w, sec_w, lock_w, gain, loss;
   logic [2:0] cfg_idx;

   // fixed one-wait-state slave: data and error are registered in the same cycle as pready
   always_comb begin
      access = i_psel & i_penable;
      take = access & pready_reg;
      wr = take & i_pwrite;
      cfg_idx = i_paddr[4:2];
      mapped = is_cfg(i_paddr) | hit(i_paddr, `PCSU_CTRL_OFF) | hit(i_paddr, `PCSU_LOCK_OFF) |
               hit(i_paddr, `PCSU_ISTAT_OFF) | hit(i_paddr, `PCSU_IMASK_OFF);
      pready_next = access & ~pready_reg;
      pslverr_next = pready_next & ~mapped;
      prdata_next = 32'h0;
      if (pready_next && !i_pwrite) begin
         if (is_cfg(i_paddr)) begin
            prdata_next = cfg_reg[cfg_idx];
         end else if (hit(i_paddr, `PCSU_CTRL_OFF)) begin
            prdata_next = ctrl_reg;
         end else if (hit(i_paddr, `PCSU_LOCK_OFF)) begin
            prdata_next = {24'h0, lock_w};
         end else if (hit(i_paddr, `PCSU_ISTAT_OFF)) begin
            prdata_next = {16'h0, istat_reg};
         end else if (hit(i_paddr, `PCSU_IMASK_OFF)) begin
            prdata_next = {16'h0, imask_reg};
         end
      end
      for (int i = 0; i < ML; i++) begin
         cfg_next[i] = cfg_reg[i];
      end
      if (wr && is_cfg(i_paddr)) begin
         cfg_next[cfg_idx] = merge_strb(cfg_reg[cfg_idx], i_pwdata, i_pstrb);
      end
      ctrl_next = ctrl_reg;
      if (wr && hit(i_paddr, `PCSU_CTRL_OFF)) begin
         ctrl_next = merge_strb(ctrl_reg, i_pwdata, i_pstrb);
      end
      imask_next = imask_reg;
      if (wr && hit(i_paddr, `PCSU_IMASK_OFF)) begin
         imask_next = `PCSU_IRQ_W'(merge_strb({16'h0, imask_reg}, i_pwdata, i_pstrb));
      end
      gain = lock_w & ~lock_d_reg;
      loss = ~lock_w & lock_d_reg;
      istat_next = istat_reg;
      if (take && !i_pwrite && hit(i_paddr, `PCSU_ISTAT_OFF)) begin
         istat_next = '0;
      end
      // a lock change in the clearing cycle survives the read
      istat_next = istat_next | {loss, gain};
      irq_next = |(istat_next & imask_next);
   end

   for (genvar i = 0; i < ML; i++) begin : g_loop
      if (i < NUM_LOOPS) begin : g_on
         localparam int PREV = (i == 0) ? NUM_LOOPS - 1 : i - 1;
         pcsu_ctrl_s ctrl_i;
         assign ctrl_i = '{sec_en: ctrl_reg[`PCSU_SEC_EN_LSB + i],
                           rst_from_pin: ctrl_reg[`PCSU_RST_PIN_LSB + i],
                           fb_from_pin: ctrl_reg[`PCSU_FB_PIN_LSB + i],
                           sw_rst: ctrl_reg[`PCSU_SW_RST_LSB + i]};
         pcsu_loop #(
            .T_W(T_W)
         ) u_loop (
            .i_sys_clk(i_sys_clk),
            .i_rst_b(i_rst_b),
            .i_cfg(cfg_reg[i]),
            .i_ctrl(ctrl_i),
            .i_fabric_rst(i_fabric_reset[i]),
            .i_ref_pin(i_global_clock_pin[i]),
            .i_rst_pin(i_loop_reset_pin[i]),
            .i_fb_pin(i_loop_feedback_in[i]),
            .o_primary(pri_w[i]),
            .o_secondary(sec_w[i]),
            .o_lock(lock_w[i])
         );
         // an enabled secondary from the loop below (the top loop for net 0) claims this net
         assign net_next[i] = ctrl_reg[`PCSU_SEC_EN_LSB + PREV] ? sec_w[PREV] : pri_w[i];
      end else begin : g_off
         assign pri_w[i] = 1'b0;
         assign sec_w[i] = 1'b0;
         assign lock_w[i] = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         for (int i = 0; i < ML; i++) begin
            cfg_reg[i] <= `PCSU_CFG_RESET;
         end
         ctrl_reg <= `PCSU_CTRL_RESET;
         istat_reg <= '0;
         imask_reg <= `PCSU_IMASK_RESET;
         lock_d_reg <= '0;
         net_reg <= '0;
         lock_out_reg <= '0;
         irq_reg <= 1'b0;
         prdata_reg <= 32'h0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         for (int i = 0; i < ML; i++) begin
            cfg_reg[i] <= cfg_next[i];
         end
         ctrl_reg <= ctrl_next;
         istat_reg <= istat_next;
         imask_reg <= imask_next;
         lock_d_reg <= lock_w;
         net_reg <= net_next;
         lock_out_reg <= lock_w[NUM_LOOPS-1:0];
         irq_reg <= irq_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign o_prdata = prdata_reg;
   assign o_pready = pready_reg;
   assign o_pslverr = pslverr_reg;
   assign o_global_net = net_reg;
   assign o_loop_lock = lock_out_reg;
   assign o_irq = irq_reg;

endmodule

// ---- test/pcsu_ext_model.sv ----
`timescale 1ns/1ps
module pcsu_ext_model #(
   parameter int N = 8
) (
   input wire logic [N-1:0] i_net,
   input wire logic i_fb_en,
   output logic [N-1:0] o_ref,
   output logic [N-1:0] o_fb
);
   // loop g gets its own period, 32+8g sys cycles, so swapped nets show up
   for (genvar g = 0; g < N; g++) begin : g_ref
      initial begin
         o_ref[g] = 1'b0;
         forever #(64 + 16 * g) o_ref[g] = ~o_ref[g];
      end
   end
   // board trace returns the net late; an unrouted pin shows the inverse
   assign #3 o_fb = i_fb_en ? i_net : ~i_net;
endmodule

// ---- test/pcsu_top_props.sv ----
`timescale 1ns/1ps
`include "pcsu_params.svh"
module pcsu_top_props #(
   parameter int NUM_LOOPS = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [`PCSU_ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [NUM_LOOPS-1:0] i_global_clock_pin,
   input wire logic [NUM_LOOPS-1:0] i_loop_reset_pin,
   input wire logic [NUM_LOOPS-1:0] i_loop_feedback_in,
   input wire logic [NUM_LOOPS-1:0] i_fabric_reset,
   input wire logic [NUM_LOOPS-1:0] o_global_net,
   input wire logic [NUM_LOOPS-1:0] o_loop_lock,
   input wire logic o_irq
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_b);
   // cfg slots past the built loops are refused too
   logic bad_addr;
   // loops whose reset follows the pin ignore the fabric reset
   logic [7:0] pin_sel;
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         pin_sel <= 8'h00;
      end else if (i_psel && i_penable && o_pready && i_pwrite && !o_pslverr && i_paddr[11:2] == 10'h008 &&
                   i_pstrb[1]) begin
         pin_sel <= i_pwdata[15:8];
      end
   end
   assign bad_addr = (i_paddr[11:2] >= 10'd12) || (i_paddr[11:2] >= 10'(NUM_LOOPS) && i_paddr[11:2] < 10'd8);
   a_ready_one_wait: assert property (i_psel && $rose(i_penable) |-> !o_pready ##1 o_pready)
      else $error("ready not in second access cycle");
   a_ready_pulse: assert property (o_pready |=> !o_pready)
      else $error("ready longer than one cycle");
   a_ready_in_access: assert property (o_pready |-> i_psel && i_penable && $past(i_penable))
      else $error("ready outside an access phase");
   a_err_on_unmapped: assert property (o_pready |-> o_pslverr == bad_addr)
      else $error("slave error does not match address");
   a_err_needs_ready: assert property (o_pslverr |-> o_pready)
      else $error("slave error without ready");
   a_data_quiet: assert property (!o_pready |-> o_prdata == 32'h0)
      else $error("read data outside ready cycle");
   a_reset_clears: assert property ($rose(i_rst_b) |-> o_global_net == '0 && o_loop_lock == '0 && !o_irq)
      else $error("outputs not cleared by reset");
   for (genvar g = 0; g < NUM_LOOPS; g++) begin : g_loop
      a_lock_off_reset: assert property ((i_fabric_reset[g] && !pin_sel[g]) [*5] |-> !o_loop_lock[g])
         else $error("lock stays high under loop reset");
   end
endmodule

bind pcsu_top pcsu_top_props #(.NUM_LOOPS(NUM_LOOPS)) u_props (
   .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_global_clock_pin(i_global_clock_pin), .i_loop_reset_pin(i_loop_reset_pin),
   .i_loop_feedback_in(i_loop_feedback_in), .i_fabric_reset(i_fabric_reset),
   .o_global_net(o_global_net), .o_loop_lock(o_loop_lock), .o_irq(o_irq));

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`include "pcsu_params.svh"
module tb_top;
   localparam int NL = 8;
   logic i_sys_clk, i_rst_b, psel, pen, pwr, pready, pslverr, irq, fb_en, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [NL-1:0] ref_pin, rst_pin, fb_pin, fab_rst, net, lock;
   int bad_count = 0;
   int num_checks = 0;
   int p;
   logic [31:0] cfgs [4] = '{32'h01010101, 32'h01010201, 32'h01020201, 32'h01010102};
   int pers [4] = '{32, 16, 16, 64};

   pcsu_top #(.NUM_LOOPS(NL), .T_W(16)) dut (
      .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_global_clock_pin(ref_pin), .i_loop_reset_pin(rst_pin),
      .i_loop_feedback_in(fb_pin), .i_fabric_reset(fab_rst), .o_global_net(net),
      .o_loop_lock(lock), .o_irq(irq));
   pcsu_ext_model #(.N(NL)) ext (.i_net(net), .i_fb_en(fb_en), .o_ref(ref_pin), .o_fb(fb_pin));

   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // idle cycle after release so the next setup never lands in the same step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_sys_clk);
      pen <= 1'b1;
      do @(posedge i_sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge i_sys_clk);
   endtask

   task automatic clk_n(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask

   task automatic wait_lock(input logic [NL-1:0] m);
      for (int i = 0; i < 12000 && lock !== m; i++) @(posedge i_sys_clk);
      check("lock", {24'h0, lock}, {24'h0, m});
   endtask

   // first edge skipped: it may be the seam of a switch-over
   task automatic period(input int i);
      realtime t0;
      @(posedge net[i]);
      @(posedge net[i]);
      t0 = $realtime;
      @(posedge net[i]);
      p = int'(($realtime - t0) / 4.0);
   endtask

   task automatic restart0(input logic [31:0] ctrl);
      apb(1'b1, `PCSU_CTRL_OFF, ctrl | 32'h01000000);
      clk_n(6);
      check("lock0 in reset", {31'h0, lock[0]}, 32'h0);
      apb(1'b1, `PCSU_CTRL_OFF, ctrl);
      wait_lock(8'hff);
   endtask

   task automatic t_regs();
      for (int i = 0; i < NL; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         check("cfg reset", rd, `PCSU_CFG_RESET);
      end
      apb(1'b0, `PCSU_CTRL_OFF, 32'h0);
      check("ctrl reset", rd, `PCSU_CTRL_RESET);
      apb(1'b0, 12'h030, 32'h0);
      check("unmapped err", {31'h0, err}, 32'h1);
      pstrb <= 4'h1;
      apb(1'b1, `PCSU_IMASK_OFF, 32'hffffffff);
      pstrb <= 4'hf;
      apb(1'b0, `PCSU_IMASK_OFF, 32'h0);
      check("imask lane", rd, 32'h000000ff);
      apb(1'b1, `PCSU_IMASK_OFF, 32'h0);
   endtask

   task automatic t_all_lock();
      wait_lock(8'hff);
      apb(1'b1, `PCSU_LOCK_OFF, 32'h0);
      apb(1'b0, `PCSU_LOCK_OFF, 32'h0);
      check("lock reg", rd, 32'h000000ff);
      apb(1'b0, `PCSU_ISTAT_OFF, 32'h0);
      check("gain events", rd, 32'h000000ff);
      apb(1'b0, `PCSU_ISTAT_OFF, 32'h0);
      check("read clears", rd, 32'h0);
      for (int i = 0; i < NL; i++) begin
         period(i);
         check("net period", p, 32 + 8 * i);
      end
   endtask

   task automatic t_dividers();
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, `PCSU_CFG_BASE, cfgs[k]);
         restart0(32'h0);
         period(0);
         check("divided period", p, pers[k]);
      end
   endtask

   task automatic t_secondary();
      apb(1'b1, `PCSU_CFG_BASE, 32'h03010201);
      restart0(32'h0);
      apb(1'b1, `PCSU_CTRL_OFF, 32'h00000001);
      period(1);
      check("secondary", p, 48);
      period(0);
      check("primary kept", p, 16);
      apb(1'b1, `PCSU_CTRL_OFF, 32'h0);
      period(1);
      check("net1 own", p, 40);
   endtask

   task automatic t_feedback();
      fb_en <= 1'b1;
      restart0(32'h00010000);
      period(0);
      check("board loop", p, 16);
      fb_en <= 1'b0;
      restart0(32'h0);
   endtask

   task automatic t_resets();
      apb(1'b0, `PCSU_ISTAT_OFF, 32'h0);
      apb(1'b1, `PCSU_IMASK_OFF, 32'h00000400);
      fab_rst[2] <= 1'b1;
      clk_n(8);
      check("lock2 reset", {31'h0, lock[2]}, 32'h0);
      check("irq loss", {31'h0, irq}, 32'h1);
      fab_rst[2] <= 1'b0;
      wait_lock(8'hff);
      apb(1'b0, `PCSU_ISTAT_OFF, 32'h0);
      check("loss gain", rd, 32'h00000404);
      clk_n(2);
      check("irq cleared", {31'h0, irq}, 32'h0);
      rst_pin[3] <= 1'b1;
      clk_n(20);
      check("pin unselected", {31'h0, lock[3]}, 32'h1);
      apb(1'b1, `PCSU_CTRL_OFF, 32'h00000800);
      clk_n(8);
      check("pin reset", {31'h0, lock[3]}, 32'h0);
      rst_pin[3] <= 1'b0;
      wait_lock(8'hff);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      i_rst_b = 1'b0;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      rst_pin = '0;
      fab_rst = '0;
      fb_en = 1'b0;
      clk_n(5);
      i_rst_b <= 1'b1;
      t_regs();
      t_all_lock();
      t_dividers();
      t_secondary();
      t_feedback();
      t_resets();
      wrap_up();
   end

   // about three times the slowest expected run of all relocks
   initial begin
      #(90000 * 4);
      bad_count++;
      wrap_up();
   end
endmodule
